// File: hw/mcs_regs.vh
`ifndef MCS_REGS_VH
`define MCS_REGS_VH

// Register byte offsets on the AXI4-Lite slave
`define MCS_OFS_MFG_INIT      8'h00
`define MCS_OFS_MFG_LIVE      8'h04
`define MCS_OFS_CMD           8'h08
`define MCS_OFS_CTRL          8'h0c
`define MCS_OFS_SW_TEST       8'h10
`define MCS_OFS_STATUS        8'h14
`define MCS_OFS_RES_FIRST     8'h20
`define MCS_OFS_RES_LAST      8'h44
`define MCS_OFS_RES_FIRST_W   6'h08  // Word index of the first resistance register

// Number of cells with a link resistance setting
`define MCS_CELL_COUNT        10
`define MCS_CELL_IDX_LAST     4'h9

// Manufacturing status word fields
`define MCS_MFG_NVM_WE_BIT    7
`define MCS_MFG_PERMANENT_FAILURE_CHECK_ENABLE_BIT     6
`define MCS_MFG_SW_NORMAL_BIT 4
`define MCS_MFG_INIT_RESET    16'h0040
`define MCS_MFG_USED_MASK     16'h00d0

// Command register bits
`define MCS_CMD_LOCK_BIT      0
`define MCS_CMD_EDIT_ENTER    1
`define MCS_CMD_EDIT_EXIT     2

// Control register bits
`define MCS_CTRL_UNRESTR_BIT  0

// Status register bits
`define MCS_STAT_EDIT_BIT     0
`define MCS_STAT_PF_BIT       1
`define MCS_STAT_SWTEST_BIT   2

// Link resistance limits and reset
`define MCS_RES_RESET         16'h0000
`define MCS_RES_MAX           16'h7fff

// Current times resistance gives microvolts; scale to millivolts
`define MCS_UV_PER_MV         32'sd1000
`define MCS_MV_MAX            34'sh0_0000_7fff
`define MCS_MV_MIN            34'sh3_ffff_8000

// Runtime memory programming request kinds
`define MCS_NVM_DIAG          2'h0
`define MCS_NVM_FUSE          2'h1
`define MCS_NVM_SCRATCH       2'h2

// AXI response codes
`define MCS_RESP_OKAY         2'h0
`define MCS_RESP_SLVERR       2'h2

`endif

// File: hw/mcs_res_cell.v
`timescale 1ns/100ps
`include "mcs_regs.vh"

// One link resistance setting with byte-lane writes and clamping
module mcs_res_cell (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  // Write side
  input  wire        wr_en,
  input  wire [1:0]  wr_strb,
  input  wire [15:0] wr_data,
  // Stored value
  output reg  [15:0] value_q
);

  reg [15:0] merged;

  // Merge enabled byte lanes over the held value
  always @* begin
    merged = value_q;
    if (wr_strb[0]) begin
      merged[7:0] = wr_data[7:0];
    end
    if (wr_strb[1]) begin
      merged[15:8] = wr_data[15:8];
    end
  end

  // Store; a negative value is clamped to zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      value_q <= `MCS_RES_RESET;
    end else if (ce && wr_en) begin
      value_q <= merged[15] ? `MCS_RES_RESET : (merged & `MCS_RES_MAX);
    end
  end

endmodule // mcs_res_cell

// File: hw/mcs_cell_corr.v
`timescale 1ns/100ps
`include "mcs_regs.vh"

// Removes the link drop (current times resistance) from a cell reading
module mcs_cell_corr (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  // Raw sample
  input  wire        in_valid,
  input  wire [3:0]  in_idx,
  input  wire [15:0] in_mv,
  input  wire [15:0] in_ma,
  input  wire [15:0] in_res,
  // Corrected sample
  output reg         out_valid_q,
  output reg  [3:0]  out_idx_q,
  output reg  [15:0] out_mv_q
);

  wire signed [31:0] prod_uv;
  wire signed [31:0] drop_mv;
  wire signed [33:0] diff_mv;

  // Drop in millivolts, truncated toward zero
  assign prod_uv = $signed(in_ma) * $signed({1'b0, in_res[14:0]});
  assign drop_mv = prod_uv / `MCS_UV_PER_MV;
  assign diff_mv = {{18{in_mv[15]}}, in_mv} - {{2{drop_mv[31]}}, drop_mv};

  // Register result, saturated to 16-bit signed
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid_q <= 1'b0;
      out_idx_q   <= 4'h0;
      out_mv_q    <= 16'h0000;
    end else if (ce) begin
      out_valid_q <= in_valid;
      if (in_valid) begin
        out_idx_q <= in_idx;
        if (diff_mv > `MCS_MV_MAX) begin
          out_mv_q <= 16'h7fff;
        end else if (diff_mv < `MCS_MV_MIN) begin
          out_mv_q <= 16'h8000;
        end else begin
          out_mv_q <= diff_mv[15:0];
        end
      end
    end
  end

endmodule // mcs_cell_corr

// File: hw/mcs_mfg_config.v
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "mcs_regs.vh"

// Operation
// - Ten signed milliohm link resistances, range 0 to 32767, reset to zero
// - Cell voltage corrected with simultaneous current and that cell's resistance
// - Reset, lock and settings-edit entry load live status from initial word
// - Bit 7 gates runtime memory writes; scratch data needs unrestricted access
// - Memory programming only while stack voltage and temperature are in limits
// - With bit 7 clear, programming still allowed in settings-edit mode
// - Bit 6, default 1, enables permanent failure; clear blocks any trigger
// - Protection may still force switches off, or on, in test mode
module mcs_mfg_config (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  input  wire        ce,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Raw cell measurement
  input  wire        meas_valid,
  input  wire [3:0]  meas_cell_idx,
  input  wire [15:0] meas_cell_mv,
  input  wire [15:0] meas_current_ma,
  // Corrected cell measurement
  output wire        corr_valid_q,
  output wire [3:0]  corr_cell_idx_q,
  output wire [15:0] corr_cell_mv_q,
  // Runtime memory programming
  input  wire        nvm_req,
  input  wire [1:0]  nvm_kind,
  input  wire        stack_in_limits,
  input  wire        temp_in_limits,
  output reg         nvm_program_q,
  output reg         nvm_refused_q,
  // Permanent failure
  input  wire        pf_detect,
  output reg         permanent_failure_q,
  // Switch control, bit 0 charge, bit 1 discharge
  input  wire [1:0]  normal_switch_on,
  input  wire [1:0]  protect_force_off,
  input  wire [1:0]  protect_force_on,
  output reg  [1:0]  switch_on_q,
  output reg         switch_test_mode_q,
  // Live manufacturing status
  output reg  [15:0] mfg_status_q
);

  // Write channel holding registers
  reg         aw_full_q;
  reg         w_full_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;

  // Block state
  reg  [15:0] mfg_init_q;
  reg         unrestricted_q;
  reg         edit_mode_q;
  reg  [1:0]  sw_test_q;

  // Write decode
  wire        wr_fire;
  wire        wr_init;
  wire        wr_live;
  wire        wr_cmd;
  wire        wr_ctrl;
  wire        wr_swtest;
  wire        wr_res_hit;
  wire [5:0]  wr_res_off;
  wire [3:0]  wr_res_idx;
  wire        wr_hit;
  wire [15:0] wr_lo;
  wire [15:0] wr_mask;

  // Command decode
  wire        cmd_lock;
  wire        cmd_enter;
  wire        cmd_exit;
  wire        reload;

  // Resistance storage and lookup
  wire [16*`MCS_CELL_COUNT-1:0] res_flat;
  wire [15:0] meas_res;

  // Read decode
  reg  [31:0] rd_data;
  reg         rd_hit;
  wire [5:0]  rd_res_off;
  wire [3:0]  rd_res_idx;

  // Live status fields
  wire        live_nvm_we;
  wire        live_permanent_failure_check_enable;
  wire        live_sw_normal;
  wire        nvm_allowed;

  assign live_nvm_we    = mfg_status_q[`MCS_MFG_NVM_WE_BIT];
  assign live_permanent_failure_check_enable     = mfg_status_q[`MCS_MFG_PERMANENT_FAILURE_CHECK_ENABLE_BIT];
  assign live_sw_normal = mfg_status_q[`MCS_MFG_SW_NORMAL_BIT];

  // Write address decode on the held address
  assign wr_fire    = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_init    = wr_fire & (aw_addr_q == `MCS_OFS_MFG_INIT);
  assign wr_live    = wr_fire & (aw_addr_q == `MCS_OFS_MFG_LIVE);
  assign wr_cmd     = wr_fire & (aw_addr_q == `MCS_OFS_CMD);
  assign wr_ctrl    = wr_fire & (aw_addr_q == `MCS_OFS_CTRL);
  assign wr_swtest  = wr_fire & (aw_addr_q == `MCS_OFS_SW_TEST);
  assign wr_res_off = aw_addr_q[7:2] - `MCS_OFS_RES_FIRST_W;
  assign wr_res_idx = wr_res_off[3:0];
  assign wr_res_hit = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q >= `MCS_OFS_RES_FIRST)
                      && (aw_addr_q <= `MCS_OFS_RES_LAST);
  assign wr_hit     = wr_init | wr_live | wr_cmd | wr_ctrl | wr_swtest
                      | (aw_addr_q == `MCS_OFS_STATUS) | wr_res_hit;

  // Byte-lane merge helper for 16-bit registers
  assign wr_lo   = w_data_q[15:0];
  assign wr_mask = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Commands act on byte lane 0 only
  assign cmd_lock  = wr_cmd & w_strb_q[0] & w_data_q[`MCS_CMD_LOCK_BIT];
  assign cmd_enter = wr_cmd & w_strb_q[0] & w_data_q[`MCS_CMD_EDIT_ENTER];
  assign cmd_exit  = wr_cmd & w_strb_q[0] & w_data_q[`MCS_CMD_EDIT_EXIT];
  assign reload    = cmd_lock | cmd_enter;

  // Write address and data capture, either order, response after both
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MCS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `MCS_RESP_OKAY : `MCS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_full_q     <= 1'b0;
        w_full_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Initial word store; reserved bits never stored
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mfg_init_q <= `MCS_MFG_INIT_RESET;
    end else if (ce && wr_init) begin
      mfg_init_q <= ((mfg_init_q & ~wr_mask) | (wr_lo & wr_mask)) & `MCS_MFG_USED_MASK;
    end
  end

  // Live status: loaded at reset and on lock or edit entry
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mfg_status_q <= `MCS_MFG_INIT_RESET;
    end else if (ce) begin
      if (reload) begin
        mfg_status_q <= mfg_init_q;
      end else if (wr_live && unrestricted_q) begin
        mfg_status_q <= ((mfg_status_q & ~wr_mask) | (wr_lo & wr_mask)) & `MCS_MFG_USED_MASK;
      end
    end
  end

  // Access mode and settings-edit mode
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      unrestricted_q <= 1'b0;
      edit_mode_q    <= 1'b0;
    end else if (ce) begin
      if (cmd_lock) begin
        unrestricted_q <= 1'b0;
      end else if (wr_ctrl && w_strb_q[0]) begin
        unrestricted_q <= w_data_q[`MCS_CTRL_UNRESTR_BIT];
      end
      if (cmd_enter) begin
        edit_mode_q <= 1'b1;
      end else if (cmd_exit) begin
        edit_mode_q <= 1'b0;
      end
    end
  end

  // Ten link resistance settings
  // ten cell settings
  genvar gi;
  generate
    for (gi = 0; gi < `MCS_CELL_COUNT; gi = gi + 1) begin : g_res
      mcs_res_cell u_res (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .wr_en   (wr_fire & wr_res_hit & ({28'h0000000, wr_res_idx} == gi)),
        .wr_strb (w_strb_q[1:0]),
        .wr_data (wr_lo),
        .value_q (res_flat[16*gi +: 16])
      );
    end
  endgenerate

  // Resistance for the cell being measured; out-of-range cells get zero
  assign meas_res = (meas_cell_idx <= `MCS_CELL_IDX_LAST) ?
                    res_flat[16*meas_cell_idx +: 16] : `MCS_RES_RESET;

  mcs_cell_corr u_corr (
    .clk         (clk),
    .reset       (reset),
    .ce          (ce),
    .in_valid    (meas_valid),
    .in_idx      (meas_cell_idx),
    .in_mv       (meas_cell_mv),
    .in_ma       (meas_current_ma),
    .in_res      (meas_res),
    .out_valid_q (corr_valid_q),
    .out_idx_q   (corr_cell_idx_q),
    .out_mv_q    (corr_cell_mv_q)
  );

  // Programming permission from live status, mode and limits
  // runtime write gate
  assign nvm_allowed = (live_nvm_we | edit_mode_q) & stack_in_limits & temp_in_limits
                       & ((nvm_kind != `MCS_NVM_SCRATCH) | unrestricted_q)
                       & (nvm_kind <= `MCS_NVM_SCRATCH);

  // One-cycle grant or refusal per request
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      nvm_program_q <= 1'b0;
      nvm_refused_q <= 1'b0;
    end else if (ce) begin
      nvm_program_q <= nvm_req & nvm_allowed;
      nvm_refused_q <= nvm_req & ~nvm_allowed;
    end
  end

  // Permanent failure latch; held until reset
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      permanent_failure_q <= 1'b0;
    end else if (ce) begin
      if (pf_detect && live_permanent_failure_check_enable) begin
        permanent_failure_q <= 1'b1;
      end
    end
  end

  // Switch test command state, only accepted in test mode
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sw_test_q <= 2'h0;
    end else if (ce) begin
      if (live_sw_normal) begin
        sw_test_q <= 2'h0;
      end else if (wr_swtest && w_strb_q[0]) begin
        sw_test_q <= w_data_q[1:0];
      end
    end
  end

  // Switch outputs; protection overrides either source
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      switch_on_q        <= 2'h0;
      switch_test_mode_q <= 1'b0;
    end else if (ce) begin
      switch_test_mode_q <= ~live_sw_normal;
      switch_on_q <= ~protect_force_off
                     & (protect_force_on | (live_sw_normal ? normal_switch_on : sw_test_q));
    end
  end

  // Read address decode
  assign rd_res_off = s_axi_araddr[7:2] - `MCS_OFS_RES_FIRST_W;
  assign rd_res_idx = rd_res_off[3:0];

  // Read data mux, narrow registers zero-extended
  always @* begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `MCS_OFS_MFG_INIT: rd_data = {16'h0000, mfg_init_q};
      `MCS_OFS_MFG_LIVE: rd_data = {16'h0000, mfg_status_q};
      `MCS_OFS_CMD:      rd_data = 32'h0000_0000;
      `MCS_OFS_CTRL:     rd_data = {31'h0000_0000, unrestricted_q};
      `MCS_OFS_SW_TEST:  rd_data = {30'h0000_0000, sw_test_q};
      `MCS_OFS_STATUS:   rd_data = {29'h0000_0000, ~live_sw_normal,
                                    permanent_failure_q, edit_mode_q};
      default: begin
        if ((s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr >= `MCS_OFS_RES_FIRST)
            && (s_axi_araddr <= `MCS_OFS_RES_LAST)) begin
          rd_data = {16'h0000, res_flat[16*rd_res_idx +: 16]};
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  // Read channel: data one cycle after the address is taken
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `MCS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_data;
        s_axi_rresp   <= rd_hit ? `MCS_RESP_OKAY : `MCS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // mcs_mfg_config

// File: test/mcs_mfg_config_props.sv
`timescale 1ns/100ps
// Port-level checks on the configuration block
module mcs_mfg_config_props (
  // Clock and reset
  input logic        clk,
  input logic        reset,
  // Measurement path
  input logic        meas_valid,
  input logic [3:0]  meas_cell_idx,
  input logic        corr_valid_q,
  input logic [3:0]  corr_cell_idx_q,
  // Memory programming
  input logic        nvm_req,
  input logic [1:0]  nvm_kind,
  input logic        stack_in_limits,
  input logic        temp_in_limits,
  input logic        nvm_program_q,
  input logic        nvm_refused_q,
  // Failure and switches
  input logic        pf_detect,
  input logic        permanent_failure_q,
  input logic [1:0]  normal_switch_on,
  input logic [1:0]  protect_force_off,
  input logic [1:0]  protect_force_on,
  input logic [1:0]  switch_on_q,
  input logic        switch_test_mode_q,
  input logic [15:0] mfg_status_q
);
  // One clock domain, all checks off during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_corr_follow: assert property (
    meas_valid |=> corr_valid_q && corr_cell_idx_q == $past(meas_cell_idx))
    else $error("corrected sample missing or for the wrong cell");
  a_nvm_answer: assert property (
    nvm_req |=> nvm_program_q != nvm_refused_q)
    else $error("memory request not answered exactly once");
  a_nvm_kind: assert property (
    nvm_program_q |-> $past(nvm_req) && $past(nvm_kind) != 2'h3)
    else $error("memory grant without a valid request");
  a_nvm_limits: assert property (
    nvm_program_q |-> $past(stack_in_limits) && $past(temp_in_limits))
    else $error("memory grant outside voltage or temperature limits");
  a_pf_gate: assert property (
    $rose(permanent_failure_q) |-> $past(pf_detect) && $past(mfg_status_q[6]))
    else $error("failure raised without detect or with checks off");
  a_pf_sticky: assert property (
    permanent_failure_q |=> permanent_failure_q)
    else $error("failure flag dropped before reset");
  a_test_enter: assert property (
    !$past(reset) && !mfg_status_q[4] |=> switch_test_mode_q)
    else $error("test mode not entered with normal control bit clear");
  a_normal_follow: assert property (
    mfg_status_q[4] |=> !switch_test_mode_q && switch_on_q ==
      (~$past(protect_force_off) & ($past(protect_force_on) | $past(normal_switch_on))))
    else $error("normal switch control not followed");
  a_force_off: assert property (
    1'b1 |=> (switch_on_q & $past(protect_force_off)) == 2'b00)
    else $error("switch on while protection forces it off");
  a_force_on: assert property (
    1'b1 |=> (~switch_on_q & $past(protect_force_on) & ~$past(protect_force_off)) == 2'b00)
    else $error("switch off while protection forces it on");
  a_live_reserved: assert property (
    (mfg_status_q & 16'hff2f) == 16'h0000)
    else $error("reserved live status bit set");
endmodule // mcs_mfg_config_props

// File: test/mcs_mfg_config_bench.sv
`timescale 1ns/100ps
`include "mcs_regs.vh"
// Self-checking bench for the configuration block
module mcs_mfg_config_bench;
  // Clock, reset and design inputs
  logic        clk = 1'b0, reset = 1'b1, ce = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        meas_valid = 1'b0, nvm_req = 1'b0, pf_detect = 1'b0;
  logic        stack_in_limits = 1'b0, temp_in_limits = 1'b0;
  logic [3:0]  meas_cell_idx = 4'h0;
  logic [15:0] meas_cell_mv = 16'h0, meas_current_ma = 16'h0;
  logic [1:0]  nvm_kind = 2'h0, normal_switch_on = 2'h0;
  logic [1:0]  protect_force_off = 2'h0, protect_force_on = 2'h0;
  // Design outputs
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, switch_on_q;
  logic [31:0] s_axi_rdata;
  logic        corr_valid_q, nvm_program_q, nvm_refused_q;
  logic        permanent_failure_q, switch_test_mode_q;
  logic [3:0]  corr_cell_idx_q;
  logic [15:0] corr_cell_mv_q, mfg_status_q;
  int          mismatches = 0, comparisons = 0;
  // Register offsets and responses
  localparam logic [7:0] ofs_init = `MCS_OFS_MFG_INIT, ofs_cmd = `MCS_OFS_CMD;
  localparam logic [7:0] ofs_ctrl = `MCS_OFS_CTRL, ofs_sw = `MCS_OFS_SW_TEST;
  localparam logic [7:0] ofs_stat = `MCS_OFS_STATUS, ofs_res = `MCS_OFS_RES_FIRST;
  localparam logic [1:0] rok = `MCS_RESP_OKAY, rerr = `MCS_RESP_SLVERR;

  mcs_mfg_config u_mcs_mfg_config (.*);

  // Free-running 40 MHz clock
  always #12.5 clk = ~clk;

  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, g, e);
    end
  endtask

  task axw(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(n < 20, 1'b1);
    chk(s_axi_bresp, er);
  endtask

  task axr(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(n < 20, 1'b1);
    chk(s_axi_rdata, {16'h0000, e});
    chk(s_axi_rresp, er);
  endtask

  // Waits a few cycles for a registered answer pulse
  task settle(input logic w);
    int n;
    for (n = 0; n < 3; n++) begin
      #1;
      if ((w ? (nvm_program_q | nvm_refused_q) : corr_valid_q) === 1'b1) break;
      @(posedge clk);
    end
  endtask

  task meas(input logic [3:0] i, input logic [15:0] mv, ma, e);
    @(posedge clk);
    meas_valid      <= 1'b1;
    meas_cell_idx   <= i;
    meas_cell_mv    <= mv;
    meas_current_ma <= ma;
    @(posedge clk);
    meas_valid <= 1'b0;
    settle(1'b0);
    chk({corr_valid_q, corr_cell_idx_q, corr_cell_mv_q}, {1'b1, i, e});
  endtask

  task nvm(input logic [1:0] k, input logic st, tp, g);
    @(posedge clk);
    nvm_req         <= 1'b1;
    nvm_kind        <= k;
    stack_in_limits <= st;
    temp_in_limits  <= tp;
    @(posedge clk);
    nvm_req <= 1'b0;
    settle(1'b1);
    chk({nvm_program_q, nvm_refused_q}, {g, !g});
  endtask

  task sw(input logic [1:0] nm, off, on, e);
    @(posedge clk);
    normal_switch_on  <= nm;
    protect_force_off <= off;
    protect_force_on  <= on;
    repeat (3) @(posedge clk);
    #1 chk(switch_on_q, e);
  endtask

  task live(input logic [15:0] e);
    repeat (2) @(posedge clk);
    #1 chk(mfg_status_q, e);
  endtask

  task pf(input logic e);
    @(posedge clk) pf_detect <= 1'b1;
    repeat (3) @(posedge clk);
    pf_detect <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(permanent_failure_q, e);
  endtask

  task t_reset;
    chk(mfg_status_q, 16'h0040); // live loaded at reset
    axr(ofs_init, 16'h0040, rok); // check enable default set
    for (int k = 0; k < 10; k++) axr(8'(ofs_res + 4 * k), 16'h0000, rok); // zero reset
    $display("test reset values done");
  endtask

  task t_res;
    axw(ofs_res, 16'h0064, rok); // cell 1 setting
    axw(`MCS_OFS_RES_LAST, `MCS_RES_MAX, rok); // cell 10 top value
    axw(8'h24, 16'h1234, rok); // cell 2 setting
    axw(8'h24, 16'h8000, rok); // negative value
    axr(8'h24, 16'h0000, rok); // negative stores zero
    axr(ofs_res, 16'h0064, rok); // cell 1 readback
    axr(`MCS_OFS_RES_LAST, 16'h7fff, rok); // cell 10 readback
    axw(8'h18, 16'h1234, rerr); // unmapped write refused
    axr(8'h48, 16'h0000, rerr); // unmapped read refused
    $display("test resistance settings done");
  endtask

  task t_corr;
    meas(4'h0, 16'd3000, 16'd2000, 16'd2800); // charge drop removed
    meas(`MCS_CELL_IDX_LAST, 16'd3000, 16'hfc18, 16'h7fff); // saturates high
    meas(4'h1, 16'd3000, 16'd2000, 16'd3000); // zero resistance cell
    $display("test cell correction done");
  endtask

  task t_switch;
    chk(switch_test_mode_q, 1'b1); // default test mode
    axw(ofs_sw, 16'h0002, rok);
    sw(2'b01, 2'b00, 2'b00, 2'b10); // test bits drive switches
    sw(2'b01, 2'b10, 2'b01, 2'b01); // protection overrides test
    axw(ofs_init, 16'h0010, rok);
    axw(ofs_cmd, 16'h0001, rok);
    live(16'h0010); // lock reloads live word
    sw(2'b01, 2'b00, 2'b00, 2'b01); // normal control used
    chk(switch_test_mode_q, 1'b0); // test mode left
    axw(ofs_sw, 16'h0003, rok);
    sw(2'b00, 2'b00, 2'b00, 2'b00); // test bits ignored
    pf(1'b0); // checks disabled block failure
    $display("test switch control done");
  endtask

  task t_nvm;
    axw(ofs_init, 16'hffff, rok);
    axr(ofs_init, 16'h00d0, rok); // reserved bits read zero
    axw(ofs_cmd, 16'h0001, rok);
    live(16'h00d0); // reload on lock
    nvm(`MCS_NVM_DIAG, 1'b1, 1'b1, 1'b1); // diagnostics allowed
    nvm(`MCS_NVM_FUSE, 1'b1, 1'b1, 1'b1); // fuse state allowed
    nvm(`MCS_NVM_SCRATCH, 1'b1, 1'b1, 1'b0); // scratch needs unrestricted
    nvm(`MCS_NVM_DIAG, 1'b1, 1'b0, 1'b0); // temperature out
    nvm(`MCS_NVM_DIAG, 1'b0, 1'b1, 1'b0); // stack out
    axw(ofs_ctrl, 16'h0001, rok);
    nvm(`MCS_NVM_SCRATCH, 1'b1, 1'b1, 1'b1); // unrestricted scratch
    axw(ofs_init, 16'h0000, rok);
    axw(ofs_cmd, 16'h0002, rok);
    live(16'h0000); // reload on edit entry
    axr(ofs_stat, 16'h0005, rok); // edit and test mode
    nvm(`MCS_NVM_FUSE, 1'b1, 1'b1, 1'b1); // edit mode programs
    nvm(`MCS_NVM_FUSE, 1'b0, 1'b1, 1'b0); // limits hold in edit
    axw(ofs_cmd, 16'h0004, rok);
    nvm(`MCS_NVM_FUSE, 1'b1, 1'b1, 1'b0); // runtime writes off
    $display("test memory programming done");
  endtask

  task t_pf;
    pf(1'b0); // checks still disabled
    axw(ofs_init, 16'h0040, rok);
    axw(ofs_cmd, 16'h0001, rok);
    live(16'h0040); // reload on lock
    @(posedge clk) ce <= 1'b0;
    pf(1'b0); // frozen clock enable holds flag
    @(posedge clk) ce <= 1'b1;
    pf(1'b1); // failure latched
    axr(ofs_stat, 16'h0006, rok); // failure and test mode
    axw(ofs_ctrl, 16'h0001, rok);
    axw(`MCS_OFS_MFG_LIVE, 16'h00a0, rok);
    live(16'h0080); // unrestricted live write, reserved bit dropped
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1 chk({permanent_failure_q, mfg_status_q}, 17'h00040); // reset reloads live word
    $display("test permanent failure done");
  endtask

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    t_res;
    t_corr;
    t_switch;
    t_nvm;
    t_pf;
    report_and_stop;
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    mismatches++;
    report_and_stop;
  end
endmodule // mcs_mfg_config_bench

bind mcs_mfg_config mcs_mfg_config_props u_mcs_mfg_config_props (.*);
